// ### design/ncib_pkg.sv
// constants and types of the contactless front-end command and interrupt register bank
//
// Functional notes
// R01: control bits change only through host writes, never by internal logic
// R02: dynamic bits accept host writes and internal updates, e.g. command back to idle
// R03: write-only bits always read back as zero
// R04: with page use set, page number gives address bits A5 and A4
// R05: with page use clear, the whole address comes from the bus address
// R06: with bank enable set, register 0Fh reaches the extended set chosen by index
// R07: writing the command field starts it; reading returns the running command; reset 20h
// R08: auto poll starts a poll per periodic rising edge; cleared on field interrupt
// R09: receiver-off bit switches the analog receiver off; clearing re-enables it
// R10: power-down write one enters sleep; zero wakes; bit reads one until ready
// R11: power-down set is ignored while the soft reset command is active
// R12: interrupt pin equals global status, inverted when invert bit set; enable reset 80h
// R13: first enable bits 6..0 gate transmit, receive, idle, high, low, error, timer flags
// R14: interrupt pin is push-pull when output-type bit is one, open drain otherwise
// R15: second enable bits 6..0 gate field, wake, signal, mode, checksum, field on/off flags
// R16: first request write: bit 7 one sets, zero clears the selected flags
// R17: second request register does the same with its bit 7; bit 6 means card present
// R18: transmit flag sets right after the last transmitted bit
// R19: receive flag sets at valid stream end; with only-valid option needs FIFO bytes
// R20: idle flag sets when a command ends itself or is unknown, not on host idle
// R21: high and low level flags latch when the FIFO level turns true until cleared
// R22: error flag sets on any error bit; timer flag sets when the timer reaches zero
// R23: global interrupt status is high when any enabled flag is set
// R24: external signal activity flag sets on either edge of the external input
// R25: a hardware set in the same cycle as a host clear leaves the flag set
package ncib_pkg;
  // register indices; the byte address is four times the index
  localparam logic [5:0] NCIB_IDX_PAGE = 6'h00;
  localparam logic [5:0] NCIB_IDX_CMD = 6'h01;
  localparam logic [5:0] NCIB_IDX_COM_EN = 6'h02;
  localparam logic [5:0] NCIB_IDX_MISC_EN = 6'h03;
  localparam logic [5:0] NCIB_IDX_COM_REQ = 6'h04;
  localparam logic [5:0] NCIB_IDX_MISC_REQ = 6'h05;
  localparam logic [3:0] NCIB_IDX_EXT = 4'hF;
  // reset values
  localparam logic [7:0] NCIB_RST_PAGE = 8'h00;
  localparam logic [7:0] NCIB_RST_CMD = 8'h20;
  localparam logic [7:0] NCIB_RST_COM_EN = 8'h80;
  localparam logic [7:0] NCIB_RST_MISC_EN = 8'h00;
  localparam logic [7:0] NCIB_RST_COM_REQ = 8'h14;
  localparam logic [7:0] NCIB_RST_MISC_REQ = 8'h00;
  // field positions
  localparam int NCIB_BIT_PAGE_USE = 7;
  localparam int NCIB_BIT_BANK_EN = 6;
  localparam int NCIB_POS_SET_IDX = 2;
  localparam int NCIB_POS_PAGE_NUM = 0;
  localparam int NCIB_BIT_AUTO_POLL = 7;
  localparam int NCIB_BIT_RCV_OFF = 5;
  localparam int NCIB_BIT_PWR_DOWN = 4;
  localparam int NCIB_POS_CMD = 0;
  localparam int NCIB_BIT_INVERT = 7;
  localparam int NCIB_BIT_PUSH_PULL = 7;
  localparam int NCIB_BIT_SET_SEL = 7;
  // flag positions in the first request register
  localparam int NCIB_F_TX = 6;
  localparam int NCIB_F_RX = 5;
  localparam int NCIB_F_IDLE = 4;
  localparam int NCIB_F_HI = 3;
  localparam int NCIB_F_LO = 2;
  localparam int NCIB_F_ERR = 1;
  localparam int NCIB_F_TIMER = 0;
  // command codes; the valid mask marks which codes the engines know
  localparam logic [3:0] NCIB_CMD_IDLE = 4'h0;
  localparam logic [3:0] NCIB_CMD_SOFT_RESET = 4'hF;
  localparam logic [15:0] NCIB_CMD_VALID = 16'hFFFF;

  typedef enum logic [1:0] {
    NCIB_PD_RUN = 2'b00,
    NCIB_PD_DOWN = 2'b01,
    NCIB_PD_WAKE = 2'b10
  } ncib_pd_t;

  typedef enum logic [1:0] {
    NCIB_POLL_IDLE = 2'b00,
    NCIB_POLL_RUN = 2'b01,
    NCIB_POLL_SLEEP = 2'b10
  } ncib_poll_t;
endpackage : ncib_pkg

// ### design/ncib_top.sv
// command, power and interrupt register bank with apb slave and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module ncib_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_last_bit_sent,
  input wire logic rx_valid_end,
  input wire logic rx_fifo_has_bytes,
  input wire logic receive_only_valid_bytes,
  input wire logic fifo_high_level,
  input wire logic fifo_low_level,
  input wire logic [7:0] error_status,
  input wire logic timer_zero,
  input wire logic field_strength_evt,
  input wire logic timed_wake_evt,
  input wire logic external_signal_input,
  input wire logic mode_detect_evt,
  input wire logic checksum_done_evt,
  input wire logic field_on_evt,
  input wire logic field_off_evt,
  input wire logic cmd_done,
  input wire logic wake_done,
  input wire logic low_power_detect_mode,
  input wire logic periodic_signal,
  input wire logic poll_done,
  output logic cmd_start,
  output logic [3:0] active_command,
  output logic receiver_analog_off,
  output logic soft_power_down,
  output logic poll_start,
  output logic poll_sleep,
  output logic ext_access,
  output logic [3:0] ext_set_index,
  output logic irq_status,
  output logic irq_pin_out,
  output logic irq_pin_oe
);

  typedef struct packed {
    logic [7:0] page;
    logic auto_poll;
    logic rcv_off;
    ncib_pkg::ncib_pd_t pd;
    logic [3:0] cmd;
    logic [7:0] com_en;
    logic [7:0] misc_en;
    logic [6:0] com_flags;
    logic [6:0] misc_flags;
    logic [2:0] sig_sync;
    logic [2:0] tick_sync;
    logic sig_lvl;
    logic tick_lvl;
    logic hi_prev;
    logic lo_prev;
    ncib_pkg::ncib_poll_t poll;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic cmd_start;
    logic poll_start;
    logic ext_access;
    logic irq_status;
    logic irq_out;
    logic irq_oe;
    logic pd_down;
    logic poll_wait;
  } ncib_state_t;

  ncib_state_t st_reg;
  ncib_state_t st_next;

  logic [5:0] eff_addr;
  logic hit_page;
  logic hit_main;
  logic hit_ext;
  logic [7:0] rd_val;
  logic access;
  logic wr_done;
  logic [6:0] com_ev;
  logic [6:0] misc_ev;
  logic [6:0] com_clr;
  logic [6:0] misc_clr;
  logic [6:0] com_set;
  logic [6:0] misc_set;
  logic global_irq;
  logic sig_edge;
  logic tick_rise;
  logic [3:0] new_cmd;
  logic host_idle;

  always_comb begin
    st_next = st_reg;
    // the page number only overrides the top address bits when enabled
    if (st_reg.page[ncib_pkg::NCIB_BIT_PAGE_USE]) begin
      eff_addr = {st_reg.page[ncib_pkg::NCIB_POS_PAGE_NUM +: 2], paddr[5:2]}; // see R04
    end else begin
      eff_addr = paddr[7:2]; // see R05
    end
    // the page register shows up at index 0 of every page
    hit_page = (eff_addr[3:0] == ncib_pkg::NCIB_IDX_PAGE[3:0]);
    hit_main = (eff_addr >= ncib_pkg::NCIB_IDX_CMD) && (eff_addr <= ncib_pkg::NCIB_IDX_MISC_REQ);
    hit_ext = (eff_addr[5:4] == 2'b00) && (eff_addr[3:0] == ncib_pkg::NCIB_IDX_EXT)
      && st_reg.page[ncib_pkg::NCIB_BIT_BANK_EN]; // see R06
    rd_val = 8'h00;
    if (hit_page) begin
      rd_val = st_reg.page;
    end else begin
      case (eff_addr)
        ncib_pkg::NCIB_IDX_CMD: begin
          rd_val[ncib_pkg::NCIB_BIT_AUTO_POLL] = st_reg.auto_poll;
          rd_val[ncib_pkg::NCIB_BIT_RCV_OFF] = st_reg.rcv_off;
          rd_val[ncib_pkg::NCIB_BIT_PWR_DOWN] = (st_reg.pd != ncib_pkg::NCIB_PD_RUN); // see R10
          rd_val[ncib_pkg::NCIB_POS_CMD +: 4] = st_reg.cmd; // see R07
        end
        ncib_pkg::NCIB_IDX_COM_EN: rd_val = st_reg.com_en;
        ncib_pkg::NCIB_IDX_MISC_EN: rd_val = st_reg.misc_en;
        ncib_pkg::NCIB_IDX_COM_REQ: rd_val = {1'b0, st_reg.com_flags}; // see R03
        ncib_pkg::NCIB_IDX_MISC_REQ: rd_val = {1'b0, st_reg.misc_flags}; // see R03
        default: rd_val = 8'h00;
      endcase
    end

    // apb: pready rises in the second access cycle; the write lands with it
    access = psel && penable;
    wr_done = access && st_reg.pready && pwrite;
    st_next.pready = access && !st_reg.pready;
    st_next.cmd_start = 1'b0;
    st_next.ext_access = 1'b0;
    st_next.poll_start = 1'b0;
    if (access && !st_reg.pready) begin
      st_next.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
      st_next.pslverr = !(hit_page || hit_main || hit_ext);
    end

    // pin inputs: three stages, a level change counts once stages two and three agree
    st_next.sig_sync = {st_reg.sig_sync[1:0], external_signal_input};
    st_next.tick_sync = {st_reg.tick_sync[1:0], periodic_signal};
    if (st_reg.sig_sync[1] == st_reg.sig_sync[2]) begin
      st_next.sig_lvl = st_reg.sig_sync[2];
    end
    if (st_reg.tick_sync[1] == st_reg.tick_sync[2]) begin
      st_next.tick_lvl = st_reg.tick_sync[2];
    end
    sig_edge = (st_next.sig_lvl != st_reg.sig_lvl); // see R24
    tick_rise = st_next.tick_lvl && !st_reg.tick_lvl;
    st_next.hi_prev = fifo_high_level;
    st_next.lo_prev = fifo_low_level;

    // command engine: completion and unknown codes fall back to idle
    new_cmd = pwdata[ncib_pkg::NCIB_POS_CMD +: 4];
    host_idle = 1'b0;
    com_ev = '0;
    if (cmd_done && st_reg.cmd != ncib_pkg::NCIB_CMD_IDLE) begin
      st_next.cmd = ncib_pkg::NCIB_CMD_IDLE; // see R02
      com_ev[ncib_pkg::NCIB_F_IDLE] = 1'b1; // see R20
    end

    com_clr = '0;
    misc_clr = '0;
    com_set = '0;
    misc_set = '0;
    if (wr_done) begin
      if (hit_page) begin
        st_next.page = pwdata[7:0]; // see R01
      end else if (hit_ext) begin
        st_next.ext_access = 1'b1; // see R06
      end else begin
        case (eff_addr)
          ncib_pkg::NCIB_IDX_CMD: begin
            st_next.auto_poll = pwdata[ncib_pkg::NCIB_BIT_AUTO_POLL];
            st_next.rcv_off = pwdata[ncib_pkg::NCIB_BIT_RCV_OFF]; // see R09
            if (pwdata[ncib_pkg::NCIB_BIT_PWR_DOWN]) begin
              // a running soft reset must finish before sleep is allowed
              if (st_reg.cmd != ncib_pkg::NCIB_CMD_SOFT_RESET) begin
                st_next.pd = ncib_pkg::NCIB_PD_DOWN; // see R11
              end
            end else if (st_reg.pd == ncib_pkg::NCIB_PD_DOWN) begin
              st_next.pd = ncib_pkg::NCIB_PD_WAKE; // see R10
            end
            if (new_cmd == ncib_pkg::NCIB_CMD_IDLE) begin
              st_next.cmd = ncib_pkg::NCIB_CMD_IDLE;
              host_idle = 1'b1; // see R20
              com_ev[ncib_pkg::NCIB_F_IDLE] = 1'b0;
            end else if (ncib_pkg::NCIB_CMD_VALID[new_cmd]) begin
              st_next.cmd = new_cmd; // see R07
              st_next.cmd_start = 1'b1;
            end else begin
              st_next.cmd = ncib_pkg::NCIB_CMD_IDLE;
              com_ev[ncib_pkg::NCIB_F_IDLE] = 1'b1; // see R20
            end
          end
          ncib_pkg::NCIB_IDX_COM_EN: st_next.com_en = pwdata[7:0];
          ncib_pkg::NCIB_IDX_MISC_EN: st_next.misc_en = pwdata[7:0];
          ncib_pkg::NCIB_IDX_COM_REQ: begin
            if (pwdata[ncib_pkg::NCIB_BIT_SET_SEL]) begin
              com_set = pwdata[6:0]; // see R16
            end else begin
              com_clr = pwdata[6:0]; // see R16
            end
          end
          ncib_pkg::NCIB_IDX_MISC_REQ: begin
            if (pwdata[ncib_pkg::NCIB_BIT_SET_SEL]) begin
              misc_set = pwdata[6:0]; // see R17
            end else begin
              misc_clr = pwdata[6:0]; // see R17
            end
          end
          default: st_next.ext_access = 1'b0;
        endcase
      end
    end
    if (st_reg.pd == ncib_pkg::NCIB_PD_WAKE && wake_done) begin
      st_next.pd = ncib_pkg::NCIB_PD_RUN; // see R10
    end

    // hardware events
    com_ev[ncib_pkg::NCIB_F_TX] = tx_last_bit_sent; // see R18
    com_ev[ncib_pkg::NCIB_F_RX] = rx_valid_end
      && (!receive_only_valid_bytes || rx_fifo_has_bytes); // see R19
    com_ev[ncib_pkg::NCIB_F_HI] = fifo_high_level && !st_reg.hi_prev; // see R21
    com_ev[ncib_pkg::NCIB_F_LO] = fifo_low_level && !st_reg.lo_prev; // see R21
    com_ev[ncib_pkg::NCIB_F_ERR] = |error_status; // see R22
    com_ev[ncib_pkg::NCIB_F_TIMER] = timer_zero; // see R22
    misc_ev = {field_strength_evt, timed_wake_evt, sig_edge, mode_detect_evt,
      checksum_done_evt, field_on_evt, field_off_evt}; // see R17
    // set wins over clear so no event is lost
    st_next.com_flags = (st_reg.com_flags & ~com_clr) | com_set | com_ev; // see R25
    st_next.misc_flags = (st_reg.misc_flags & ~misc_clr) | misc_set | misc_ev; // see R25

    // auto poll sequencer in low-power detect mode
    case (st_reg.poll)
      ncib_pkg::NCIB_POLL_IDLE, ncib_pkg::NCIB_POLL_SLEEP: begin
        if (st_reg.auto_poll && low_power_detect_mode && tick_rise) begin
          st_next.poll = ncib_pkg::NCIB_POLL_RUN; // see R08
          st_next.poll_start = 1'b1;
        end else if (!st_reg.auto_poll || !low_power_detect_mode) begin
          st_next.poll = ncib_pkg::NCIB_POLL_IDLE;
        end
      end
      ncib_pkg::NCIB_POLL_RUN: begin
        if (field_strength_evt) begin
          st_next.auto_poll = 1'b0; // see R08
          st_next.poll = ncib_pkg::NCIB_POLL_IDLE;
        end else if (poll_done) begin
          st_next.poll = ncib_pkg::NCIB_POLL_SLEEP; // see R08
        end
      end
      default: st_next.poll = ncib_pkg::NCIB_POLL_IDLE;
    endcase
    // decoded from the next state so these outputs come straight from flops
    st_next.pd_down = (st_next.pd == ncib_pkg::NCIB_PD_DOWN); // see R10
    st_next.poll_wait = (st_next.poll == ncib_pkg::NCIB_POLL_SLEEP); // see R08

    // interrupt pin from the registered flags
    global_irq = |(st_reg.com_flags & st_reg.com_en[6:0])
      | |(st_reg.misc_flags & st_reg.misc_en[6:0]); // see R13, R15, R23
    st_next.irq_status = global_irq; // see R23
    if (st_reg.misc_en[ncib_pkg::NCIB_BIT_PUSH_PULL]) begin
      st_next.irq_out = global_irq ^ st_reg.com_en[ncib_pkg::NCIB_BIT_INVERT]; // see R12
      st_next.irq_oe = 1'b1; // see R14
    end else begin
      // open drain only pulls low; a high level is left to the pull-up
      st_next.irq_out = 1'b0;
      st_next.irq_oe = !(global_irq ^ st_reg.com_en[ncib_pkg::NCIB_BIT_INVERT]); // see R14
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.page <= ncib_pkg::NCIB_RST_PAGE;
      st_reg.auto_poll <= ncib_pkg::NCIB_RST_CMD[ncib_pkg::NCIB_BIT_AUTO_POLL];
      st_reg.rcv_off <= ncib_pkg::NCIB_RST_CMD[ncib_pkg::NCIB_BIT_RCV_OFF];
      st_reg.pd <= ncib_pkg::NCIB_PD_RUN;
      st_reg.cmd <= ncib_pkg::NCIB_RST_CMD[3:0];
      st_reg.com_en <= ncib_pkg::NCIB_RST_COM_EN; // see R12
      st_reg.misc_en <= ncib_pkg::NCIB_RST_MISC_EN;
      st_reg.com_flags <= ncib_pkg::NCIB_RST_COM_REQ[6:0];
      st_reg.misc_flags <= ncib_pkg::NCIB_RST_MISC_REQ[6:0];
      st_reg.poll <= ncib_pkg::NCIB_POLL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign cmd_start = st_reg.cmd_start;
  assign active_command = st_reg.cmd;
  assign receiver_analog_off = st_reg.rcv_off;
  assign soft_power_down = st_reg.pd_down;
  assign poll_start = st_reg.poll_start;
  assign poll_sleep = st_reg.poll_wait;
  assign ext_access = st_reg.ext_access;
  assign ext_set_index = st_reg.page[ncib_pkg::NCIB_POS_SET_IDX +: 4];
  assign irq_status = st_reg.irq_status;
  assign irq_pin_out = st_reg.irq_out;
  assign irq_pin_oe = st_reg.irq_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_req_wonly;
    access && !pwrite && !st_reg.pready && (eff_addr == ncib_pkg::NCIB_IDX_COM_REQ)
      |=> pready && !prdata[7];
  endproperty
  a_req_wonly: assert property (p_req_wonly) else $error("write-only bit read as one"); // see R03

  property p_irq_pp;
    st_reg.misc_en[7] |=> irq_pin_oe && (irq_pin_out == ($past(global_irq) ^ $past(st_reg.com_en[7])));
  endproperty
  a_irq_pp: assert property (p_irq_pp) else $error("push-pull pin level wrong"); // see R12

  property p_irq_od;
    !st_reg.misc_en[7] |=> !irq_pin_out && (irq_pin_oe == !($past(global_irq) ^ $past(st_reg.com_en[7])));
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("open drain pin wrong"); // see R14

  property p_set_wins;
    |com_ev |=> ((st_reg.com_flags & $past(com_ev)) == $past(com_ev));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear"); // see R25

  property p_masked_clr;
    wr_done && (eff_addr == ncib_pkg::NCIB_IDX_COM_REQ) && !pwdata[7] && !hit_page && (com_ev == 7'h00)
      |=> st_reg.com_flags == ($past(st_reg.com_flags) & ~$past(pwdata[6:0]));
  endproperty
  a_masked_clr: assert property (p_masked_clr) else $error("masked clear wrong"); // see R16

  property p_unknown_cmd;
    wr_done && !hit_page && (eff_addr == ncib_pkg::NCIB_IDX_CMD) && (new_cmd != 4'h0)
      && !ncib_pkg::NCIB_CMD_VALID[new_cmd]
      |=> (st_reg.cmd == ncib_pkg::NCIB_CMD_IDLE) && st_reg.com_flags[4];
  endproperty
  a_unknown_cmd: assert property (p_unknown_cmd) else $error("unknown command kept"); // see R20

  property p_host_idle;
    host_idle && !st_reg.com_flags[4] |=> !st_reg.com_flags[4];
  endproperty
  a_host_idle: assert property (p_host_idle) else $error("host idle set idle flag"); // see R20

  property p_sr_block;
    wr_done && !hit_page && (eff_addr == ncib_pkg::NCIB_IDX_CMD)
      && (st_reg.cmd == ncib_pkg::NCIB_CMD_SOFT_RESET) && (st_reg.pd == ncib_pkg::NCIB_PD_RUN)
      |=> !soft_power_down;
  endproperty
  a_sr_block: assert property (p_sr_block) else $error("power-down during soft reset"); // see R11

  property p_wake_one;
    (st_reg.pd == ncib_pkg::NCIB_PD_WAKE) |-> rd_val[4] || !(eff_addr == ncib_pkg::NCIB_IDX_CMD) || hit_page;
  endproperty
  a_wake_one: assert property (p_wake_one) else $error("power bit low while waking"); // see R10

  property p_poll;
    (st_reg.poll != ncib_pkg::NCIB_POLL_RUN) && st_reg.auto_poll && low_power_detect_mode && tick_rise
      |=> poll_start ##1 !poll_start;
  endproperty
  a_poll: assert property (p_poll) else $error("poll not started"); // see R08

  property p_sig_edge;
    sig_edge |=> st_reg.misc_flags[4];
  endproperty
  a_sig_edge: assert property (p_sig_edge) else $error("signal edge lost"); // see R24

  c_unknown: cover property (p_unknown_cmd);
  c_poll_sleep: cover property (st_reg.poll == ncib_pkg::NCIB_POLL_RUN ##1 poll_sleep);
  c_irq_fire: cover property ($rose(irq_status));

endmodule : ncib_top
`default_nettype wire

// ### test/ncib_host_model.sv
// apb host model that issues register transfers on behalf of the bench
`timescale 1ns/1ps
`default_nettype none
module ncib_host_model (
  input wire logic clk,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // request stays unchanged until the edge that sees pready; only the bench timeout ends a wait
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : ncib_host_model
`default_nettype wire

// ### test/ncib_top_tb.sv
// self-checking bench for the command and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module ncib_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  logic [11:0] ev = 12'h000;
  logic [7:0] err_st = 8'h00;
  logic rxb = 1'b0, rxo = 1'b0, fhi = 1'b0, flo = 1'b0, ext_in = 1'b0, lpd = 1'b0, per = 1'b0;
  logic [3:0] active_command, ext_set_index;
  logic receiver_analog_off, soft_power_down, irq_status, irq_pin_out, irq_pin_oe;
  logic cmd_start, poll_start, poll_sleep, ext_access;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_cmd = 0, n_poll = 0, n_ext = 0;
  int pos[9] = '{6, 5, 0, 6, 5, 3, 2, 1, 0};

  always #5 clk = ~clk;

  ncib_host_model host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);

  ncib_top dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_last_bit_sent(ev[0]), .rx_valid_end(ev[1]), .rx_fifo_has_bytes(rxb),
    .receive_only_valid_bytes(rxo), .fifo_high_level(fhi), .fifo_low_level(flo),
    .error_status(err_st), .timer_zero(ev[2]), .field_strength_evt(ev[3]),
    .timed_wake_evt(ev[4]), .external_signal_input(ext_in), .mode_detect_evt(ev[5]),
    .checksum_done_evt(ev[6]), .field_on_evt(ev[7]), .field_off_evt(ev[8]),
    .cmd_done(ev[9]), .wake_done(ev[10]), .low_power_detect_mode(lpd),
    .periodic_signal(per), .poll_done(ev[11]), .cmd_start, .active_command,
    .receiver_analog_off, .soft_power_down, .poll_start, .poll_sleep, .ext_access,
    .ext_set_index, .irq_status, .irq_pin_out, .irq_pin_oe);

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic x;
    host.xfer(1'b1, {idx, 2'b00}, {24'h000000, d}, r, x);
  endtask : wr

  task automatic rdchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic x;
    host.xfer(1'b0, {idx, 2'b00}, 32'h00000000, r, x);
    check(what, r, {24'h000000, exp});
    check({what, " err"}, {31'h0, x}, 32'h0);
  endtask : rdchk

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 12'h000;
  endtask : pulse

  // open drain only ever pulls low; push-pull always drives the inverted-or-not level
  task automatic pinchk(input string what, input logic s, input logic inv, input logic pp);
    logic lvl;
    lvl = s ^ inv;
    repeat (3) @(posedge clk);
    check({what, " st"}, {31'h0, irq_status}, {31'h0, s});
    check({what, " out"}, {31'h0, irq_pin_out}, {31'h0, pp & lvl});
    check({what, " oe"}, {31'h0, irq_pin_oe}, {31'h0, pp | ~lvl});
  endtask : pinchk

  // one-cycle strobes are counted so that none is missed between checks
  always @(posedge clk) begin
    if (cmd_start) n_cmd <= n_cmd + 1;
    if (poll_start) n_poll <= n_poll + 1;
    if (ext_access) n_ext <= n_ext + 1;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk("page", 6'h00, 8'h00);
    rdchk("cmd", 6'h01, 8'h20);
    rdchk("com_en", 6'h02, 8'h80);
    rdchk("misc_en", 6'h03, 8'h00);
    rdchk("com_req", 6'h04, 8'h14);
    rdchk("misc_req", 6'h05, 8'h00);
    pinchk("rst pin", 1'b0, 1'b1, 1'b0);
    wr(6'h00, 8'h7C);
    rdchk("page rw", 6'h00, 8'h7C);
    check("set idx", {28'h0, ext_set_index}, 32'hF);
    wr(6'h00, 8'h81);
    host.xfer(1'b0, 8'h04, 32'h0, q, e);
    check("page 1 err", {31'h0, e}, 32'h1);
    wr(6'h00, 8'h80);
    rdchk("page 0 cmd", 6'h21, 8'h20);
    wr(6'h00, 8'h00);
    host.xfer(1'b0, 8'h84, 32'h0, q, e);
    check("latch err", {31'h0, e}, 32'h1);
    check("latch data", q, 32'h0);
    wr(6'h00, 8'h40);
    wr(6'h0F, 8'h5A);
    rdchk("ext rd", 6'h0F, 8'h00);
    check("ext wr", n_ext, 32'h1);
    wr(6'h00, 8'h00);
    wr(6'h04, 8'hC1);
    rdchk("req set", 6'h04, 8'h55);
    wr(6'h04, 8'h14);
    rdchk("req clr", 6'h04, 8'h41);
    wr(6'h05, 8'hFF);
    rdchk("misc set", 6'h05, 8'h7F);
    wr(6'h05, 8'h40);
    rdchk("misc clr", 6'h05, 8'h3F);
    wr(6'h02, 8'h40);
    pinchk("tx en", 1'b1, 1'b0, 1'b0);
    wr(6'h02, 8'hC0);
    pinchk("invert", 1'b1, 1'b1, 1'b0);
    wr(6'h03, 8'h80);
    pinchk("push pull", 1'b1, 1'b1, 1'b1);
    wr(6'h02, 8'h00);
    wr(6'h03, 8'h81);
    pinchk("off en", 1'b1, 1'b0, 1'b1);
    wr(6'h04, 8'h7F);
    wr(6'h05, 8'h7F);
    pinchk("none", 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 9; i++) begin
      pulse(i);
      rdchk("event flag", i < 3 ? 6'h04 : 6'h05, 8'h01 << pos[i]);
      wr(i < 3 ? 6'h04 : 6'h05, 8'h7F);
    end
    @(posedge clk);
    err_st <= 8'h10;
    @(posedge clk);
    err_st <= 8'h00;
    rdchk("error", 6'h04, 8'h02);
    wr(6'h04, 8'h7F);
    rxo <= 1'b1;
    pulse(1);
    rdchk("rx empty", 6'h04, 8'h00);
    rxb <= 1'b1;
    pulse(1);
    rdchk("rx bytes", 6'h04, 8'h20);
    rxo <= 1'b0;
    fhi <= 1'b1;
    flo <= 1'b1;
    repeat (2) @(posedge clk);
    fhi <= 1'b0;
    flo <= 1'b0;
    rdchk("alerts", 6'h04, 8'h2C);
    wr(6'h04, 8'h7F);
    rdchk("alerts clr", 6'h04, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      ext_in <= ~ext_in;
      repeat (8) @(posedge clk);
      rdchk("sig edge", 6'h05, 8'h10);
      wr(6'h05, 8'h7F);
    end
    wr(6'h01, 8'h25);
    rdchk("cmd run", 6'h01, 8'h25);
    check("cmd start", n_cmd, 32'h1);
    check("act cmd", {28'h0, active_command}, 32'h5);
    check("rcv off", {31'h0, receiver_analog_off}, 32'h1);
    pulse(9);
    rdchk("cmd done", 6'h01, 8'h20);
    rdchk("idle flag", 6'h04, 8'h10);
    wr(6'h04, 8'h7F);
    wr(6'h01, 8'h00);
    rdchk("host idle", 6'h04, 8'h00);
    check("rcv on", {31'h0, receiver_analog_off}, 32'h0);
    wr(6'h01, 8'h10);
    @(posedge clk);
    check("pd", {31'h0, soft_power_down}, 32'h1);
    wr(6'h01, 8'h00);
    rdchk("waking", 6'h01, 8'h10);
    pulse(10);
    rdchk("awake", 6'h01, 8'h00);
    wr(6'h01, 8'h0F);
    wr(6'h01, 8'h1F);
    rdchk("pd blocked", 6'h01, 8'h0F);
    check("cmd starts", n_cmd, 32'h3);
    pulse(9);
    rdchk("reset done", 6'h01, 8'h00);
    lpd <= 1'b1;
    wr(6'h01, 8'h80);
    per <= 1'b1;
    repeat (8) @(posedge clk);
    check("poll start", n_poll, 32'h1);
    pulse(11);
    @(posedge clk);
    check("poll sleep", {31'h0, poll_sleep}, 32'h1);
    per <= 1'b0;
    repeat (8) @(posedge clk);
    per <= 1'b1;
    repeat (8) @(posedge clk);
    check("poll again", n_poll, 32'h2);
    pulse(3);
    rdchk("poll off", 6'h01, 8'h00);
    rdchk("card flag", 6'h05, 8'h40);
    lpd <= 1'b0;
    print_verdict();
  end
endmodule : ncib_top_tb
`default_nettype wire
